//--- design/sfrwc_map.svh
// Purpose: Constants for the serial flash register-write control block.
// Assumes: Included by bare name; definitions only.
// Notes:   Timing counts are in ref_clk cycles at 10 MHz.
// Functional notes
// - Bank write opcode plus one byte loads bank register, no latch needed.
// - Bank bit 7 enables extended addressing; else bank supplies high address.
// - Bank write leaves fail flags and busy flag untouched.
// - After legacy bank opcode, register write loads only bank bits 1:0.
// - No enable between legacy opcode and write; latch not needed then.
// - Legacy sequence closes bank access, keeps extended-address bit.
// - Any other command or select cycle after legacy opcode closes access.
// - Register write needs the latch set by a prior enable command.
// - Failed register update sets program-fail or erase-fail flag.
// - Register write runs only if select rises after 8 or 16 data bits.
// - Update starts at select rise; busy during it; latch clears after.
// - With write-disable bit 0, latch alone permits status writes.
// - Write-disable 1 and protect pin high: writes allowed with latch.
// - Write-disable 1 and protect pin low: register writes rejected.
// - Protection entered in either order, left only by pin going high.
// - Block-protect bits define a read-only region refusing program/erase.
// - Quad mode disables hardware register protection.
// - Enable opcode sets latch only if select rises after eighth bit.
// - Erase-fail is status bit 5, program-fail is status bit 6.
`ifndef SFRWC_MAP_SVH
`define SFRWC_MAP_SVH
`define SFRWC_OP_BANK_WR    8'h17
`define SFRWC_OP_BANK_LEG   8'hB9
`define SFRWC_OP_REG_WR     8'h01
`define SFRWC_OP_WR_EN      8'h06
`define SFRWC_OP_CLR_SR     8'h30
`define SFRWC_SR_BUSY       0
`define SFRWC_SR_WEL        1
`define SFRWC_SR_BP_LO      2
`define SFRWC_SR_BP_HI      4
`define SFRWC_SR_EFAIL      5
`define SFRWC_SR_PFAIL      6
`define SFRWC_SR_SWD        7
`define SFRWC_CR_QUAD       1
`define SFRWC_BAR_EXT       7
`define SFRWC_SR_RST        8'h00
`define SFRWC_CR_RST        8'h00
`define SFRWC_BAR_RST       8'h00
`define SFRWC_SR_WR_MASK    8'h9C
`define SFRWC_UPD_NS        2000
`define SFRWC_CLK_NS        100
`define SFRWC_UPD_CYC ((`SFRWC_UPD_NS + `SFRWC_CLK_NS - 1) / `SFRWC_CLK_NS)
`endif

//--- design/sfrwc_pkg.sv
// Purpose: Types for the serial flash register-write control block.
// Assumes: Nothing beyond the map header.
// Notes:   Constants live in sfrwc_map.svh.
package sfrwc_pkg;
  typedef enum logic [1:0] {SFRWC_IDLE, SFRWC_BUSY} sfrwc_upd_t;
  typedef enum logic [2:0] {
    SFRWC_K_NONE, SFRWC_K_BANK, SFRWC_K_REG, SFRWC_K_LEG
  } sfrwc_kind_t;
endpackage

//--- design/sfrwc_sync.sv
// Purpose: Two flip-flop synchroniser for a pin level.
// Assumes: Input is asynchronous to clk.
// Notes:   The first stage feeds only the second.
`timescale 1ns/1ps
`default_nettype none
module sfrwc_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic d,
  output logic      q
);
  logic meta_ff;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_ff <= RST_VAL;
      q       <= RST_VAL;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end
endmodule
`default_nettype wire

//--- design/sfrwc_shift.sv
// Purpose: Serial shift-in of command and data bits on sampled link clock.
// Assumes: Mode 0/3; data sampled on rising link clock; inputs synchronised.
// Notes:   Counts bits since select fell, saturating at 31.
`timescale 1ns/1ps
`default_nettype none
module sfrwc_shift (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        sel_act,
  input  wire logic        sck_rise,
  input  wire logic        si,
  output logic [23:0]      shreg_ff,
  output logic [4:0]       bits_ff
);
  wire        sat     = (bits_ff == 5'h1F);
  wire [23:0] nxt_sh  = {shreg_ff[22:0], si};
  always_ff @(posedge clk) begin
    if (!rst_n || !sel_act) begin
      shreg_ff <= 24'h00_0000;
      bits_ff  <= 5'h00;
    end else if (sck_rise) begin
      shreg_ff <= nxt_sh;
      bits_ff  <= sat ? bits_ff : bits_ff + 5'h01;
    end
  end
endmodule
`default_nettype wire

//--- design/sfrwc_top.sv
// Purpose: Command decode and register write control for a serial flash.
// Assumes: Link pins asynchronous; link clock much slower than ref_clk.
// Notes:   Register update is self timed; failure is injected by a pin.
`timescale 1ns/1ps
`default_nettype none
`include "sfrwc_map.svh"
module sfrwc_top #(
  parameter int UPD_CYC = `SFRWC_UPD_CYC
) (
  input  wire logic      ref_clk,
  input  wire logic      rst_n,
  input  wire logic      cs_n,
  input  wire logic      sck,
  input  wire logic      si,
  input  wire logic      wp_n,
  input  wire logic      upd_fail,
  input  wire logic      upd_fail_erase,
  input  wire logic      sector_prot_req,
  input  wire logic [2:0] sector_region,
  output logic [7:0]     status_register_1,
  output logic [7:0]     configuration_register,
  output logic [7:0]     bank_address_register,
  output logic           extended_addr_enable,
  output logic           array_cmd_refused,
  output logic           reg_write_rejected
);
  import sfrwc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic cs_n_s;
  logic sck_s;
  logic si_s;
  logic wp_n_s;
  logic sck_d_ff;
  logic cs_d_ff;
  sfrwc_sync #(.RST_VAL(1'b1)) u_cs (
    .clk  (ref_clk),
    .rst_n(rst_n),
    .d    (cs_n),
    .q    (cs_n_s)
  );
  sfrwc_sync #(.RST_VAL(1'b0)) u_sck (
    .clk  (ref_clk),
    .rst_n(rst_n),
    .d    (sck),
    .q    (sck_s)
  );
  sfrwc_sync #(.RST_VAL(1'b0)) u_si (
    .clk  (ref_clk),
    .rst_n(rst_n),
    .d    (si),
    .q    (si_s)
  );
  sfrwc_sync #(.RST_VAL(1'b1)) u_wp (
    .clk  (ref_clk),
    .rst_n(rst_n),
    .d    (wp_n),
    .q    (wp_n_s)
  );
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sck_d_ff <= 1'b0;
      cs_d_ff  <= 1'b1;
    end else begin
      sck_d_ff <= sck_s;
      cs_d_ff  <= cs_n_s;
    end
  end
  wire sck_rise = sck_s && !sck_d_ff;
  wire cs_rise  = cs_n_s && !cs_d_ff;
  wire sel_act  = !cs_n_s;

  ////////////////////////////////////////////////////////////////////////
  logic [23:0] shreg;
  logic [4:0]  bits;
  sfrwc_shift u_shift (
    .clk     (ref_clk),
    .rst_n   (rst_n),
    .sel_act (sel_act),
    .sck_rise(sck_rise),
    .si      (si_s),
    .shreg_ff(shreg),
    .bits_ff (bits)
  );

  ////////////////////////////////////////////////////////////////////////
  logic [7:0]  sr_ff;
  logic [7:0]  cr_ff;
  logic [7:0]  bar_ff;
  logic        leg_open_ff;
  logic [7:0]  pend_sr_ff;
  logic [7:0]  pend_cr_ff;
  logic        pend_cr_ok_ff;
  logic        pend_fail_ff;
  logic        pend_efail_ff;
  logic [15:0] upd_cnt_ff;
  sfrwc_upd_t  upd_ff;
  logic        refused_ff;
  logic        rejected_ff;

  function automatic logic [7:0] op_at(input logic [23:0] s,
                                       input logic [4:0] n);
    logic [7:0] r;
    r = 8'h00;
    if (n == 5'd8) begin
      r = s[7:0];
    end else if (n == 5'd16) begin
      r = s[15:8];
    end else if (n == 5'd24) begin
      r = s[23:16];
    end
    return r;
  endfunction

  wire [7:0] op_b8  = op_at(shreg, 5'd8);
  wire [7:0] op_b16 = op_at(shreg, 5'd16);
  wire [7:0] op_b24 = op_at(shreg, 5'd24);
  wire       busy   = (upd_ff == SFRWC_BUSY);
  wire       write_enable_latch    = sr_ff[`SFRWC_SR_WEL];
  wire       swd    = sr_ff[`SFRWC_SR_SWD];
  wire       quad   = cr_ff[`SFRWC_CR_QUAD];

  wire end_write_enable_cmd  = cs_rise && bits == 5'd8 && op_b8 == `SFRWC_OP_WR_EN
                   && !busy;
  wire end_clr   = cs_rise && bits == 5'd8 && op_b8 == `SFRWC_OP_CLR_SR;
  wire end_leg   = cs_rise && bits == 5'd8 && op_b8 == `SFRWC_OP_BANK_LEG;
  wire end_bank  = cs_rise && bits == 5'd16 && op_b16 == `SFRWC_OP_BANK_WR;
  wire wrr8      = cs_rise && bits == 5'd16 && op_b16 == `SFRWC_OP_REG_WR;
  wire wrr16     = cs_rise && bits == 5'd24 && op_b24 == `SFRWC_OP_REG_WR;
  wire wrr_any   = wrr8 || wrr16;
  wire leg_load  = leg_open_ff && wrr_any;
  wire hw_prot   = swd && !wp_n_s && !quad;
  wire wrr_ok    = wrr_any && !leg_open_ff && write_enable_latch && !busy && !hw_prot;
  wire [7:0] wrr_sr = wrr16 ? shreg[15:8] : shreg[7:0];

  wire [2:0] bp_bits    = sr_ff[`SFRWC_SR_BP_HI:`SFRWC_SR_BP_LO];
  wire [2:0] prot_floor = 3'd7 - bp_bits + 3'd1;
  wire       region_hit = (sector_region >= prot_floor) && (bp_bits != 3'd0);

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      bar_ff      <= `SFRWC_BAR_RST;
      leg_open_ff <= 1'b0;
    end else begin
      if (end_bank) begin
        bar_ff <= shreg[7:0];
      end else if (leg_load) begin
        bar_ff <= {bar_ff[7:2], wrr_sr[1:0]};
      end
      if (end_leg) begin
        leg_open_ff <= 1'b1;
      end else if (cs_rise) begin
        leg_open_ff <= 1'b0;
      end
    end
  end

  wire [15:0] cnt_last  = UPD_CYC[15:0] - 16'h0001;
  wire        upd_start = wrr_ok;
  wire        upd_last  = busy && (upd_cnt_ff == cnt_last);
  wire        upd_good  = upd_last && !pend_fail_ff;
  wire        set_efail = upd_last && pend_fail_ff && pend_efail_ff;
  wire        set_pfail = upd_last && pend_fail_ff && !pend_efail_ff;
  wire        clr_fail  = end_clr && !busy;
  wire        wrr_std   = wrr_any && !leg_open_ff && !busy;

  sfrwc_upd_t nxt_upd;
  always_comb begin
    nxt_upd = upd_ff;
    unique case (upd_ff)
      SFRWC_IDLE: begin
        if (upd_start) begin
          nxt_upd = SFRWC_BUSY;
        end
      end
      SFRWC_BUSY: begin
        if (upd_last) begin
          nxt_upd = SFRWC_IDLE;
        end
      end
    endcase
  end

  wire [15:0] nxt_upd_cnt = upd_start ? 16'h0000
                          : (busy && !upd_last) ? upd_cnt_ff + 16'h0001
                          : upd_cnt_ff;

  wire       nxt_busy  = (nxt_upd == SFRWC_BUSY);
  wire       nxt_wel   = !upd_last && (end_write_enable_cmd || write_enable_latch);
  wire       nxt_efail = set_efail || (sr_ff[`SFRWC_SR_EFAIL] && !clr_fail);
  wire       nxt_pfail = set_pfail || (sr_ff[`SFRWC_SR_PFAIL] && !clr_fail);
  wire [2:0] pend_bp   = pend_sr_ff[`SFRWC_SR_BP_HI:`SFRWC_SR_BP_LO];
  wire [2:0] nxt_bp    = upd_good ? pend_bp : bp_bits;
  wire       nxt_swd   = upd_good ? pend_sr_ff[`SFRWC_SR_SWD] : swd;
  // The field order below follows the bit positions of the map header.
  wire [7:0] nxt_sr    = {nxt_swd, nxt_pfail, nxt_efail, nxt_bp, nxt_wel,
                          nxt_busy};
  wire [7:0] nxt_cr    = (upd_good && pend_cr_ok_ff) ? pend_cr_ff : cr_ff;
  wire       nxt_rej   = wrr_std ? !wrr_ok : rejected_ff;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pend_sr_ff    <= 8'h00;
      pend_cr_ff    <= 8'h00;
      pend_cr_ok_ff <= 1'b0;
      pend_fail_ff  <= 1'b0;
      pend_efail_ff <= 1'b0;
    end else if (upd_start) begin
      pend_sr_ff    <= wrr_sr;
      pend_cr_ff    <= shreg[7:0];
      pend_cr_ok_ff <= wrr16;
      pend_fail_ff  <= upd_fail;
      pend_efail_ff <= upd_fail_erase;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sr_ff       <= `SFRWC_SR_RST;
      cr_ff       <= `SFRWC_CR_RST;
      upd_ff      <= SFRWC_IDLE;
      upd_cnt_ff  <= 16'h0000;
      rejected_ff <= 1'b0;
    end else begin
      sr_ff       <= nxt_sr;
      cr_ff       <= nxt_cr;
      upd_ff      <= nxt_upd;
      upd_cnt_ff  <= nxt_upd_cnt;
      rejected_ff <= nxt_rej;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      refused_ff             <= 1'b0;
      status_register_1      <= `SFRWC_SR_RST;
      configuration_register <= `SFRWC_CR_RST;
      bank_address_register  <= `SFRWC_BAR_RST;
      extended_addr_enable   <= 1'b0;
      array_cmd_refused      <= 1'b0;
      reg_write_rejected     <= 1'b0;
    end else begin
      refused_ff             <= sector_prot_req && region_hit;
      status_register_1      <= sr_ff;
      configuration_register <= cr_ff;
      bank_address_register  <= bar_ff;
      extended_addr_enable   <= bar_ff[`SFRWC_BAR_EXT];
      array_cmd_refused      <= refused_ff;
      reg_write_rejected     <= rejected_ff;
    end
  end
endmodule
`default_nettype wire

//--- tb/sfrwc_checker.sv
// Purpose: Port assertions for the register-write control block.
// Assumes: Bound to sfrwc_top; one clock domain.
// Notes:   Busy length follows UPD_CYC.
`timescale 1ns/1ps
`default_nettype none
module sfrwc_checker #(
  parameter int UPD_CYC = 20
) (
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire logic       wp_n,
  input wire logic       sector_prot_req,
  input wire logic [2:0] sector_region,
  input wire logic [7:0] status_register_1,
  input wire logic [7:0] configuration_register,
  input wire logic [7:0] bank_address_register,
  input wire logic       extended_addr_enable,
  input wire logic       array_cmd_refused
);
  logic [15:0] bsy_cnt_ff;
  wire         busy = status_register_1[0];
  wire  [2:0]  bp   = status_register_1[4:2];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge ref_clk) begin
    bsy_cnt_ff <= (!rst_n || !busy) ? 16'h0000 : bsy_cnt_ff + 16'h0001;
  end
  sequence s_upd_done;
    $fell(busy);
  endsequence
  a_busy_len: assert property (
    s_upd_done |-> bsy_cnt_ff == 16'(UPD_CYC)) else $error("busy length");
  a_wel_clear: assert property (
    s_upd_done |-> !status_register_1[1]) else $error("latch kept");
  a_wel_needed: assert property (
    $rose(busy) |-> status_register_1[1]) else $error("no latch");
  a_hw_block: assert property (
    $rose(busy) |-> !(status_register_1[7] && !configuration_register[1]
    && !$past(wp_n, 4))) else $error("write while protected");
  a_cfg_in_upd: assert property (
    $changed(configuration_register) |-> busy || $past(busy))
    else $error("config outside update");
  a_bank_flags: assert property (
    $changed(bank_address_register) |-> $stable(status_register_1[6:5])
    && $stable(busy)) else $error("bank write moved flags");
  a_ext_copy: assert property (
    $stable(bank_address_register)[*2] |->
    extended_addr_enable == bank_address_register[7]) else $error("ext");
  a_fail_upd: assert property (
    $rose(status_register_1[6:5] != 2'b00) |-> busy || $past(busy))
    else $error("fail flag outside update");
  sequence s_top_req;
    sector_prot_req && sector_region == 3'h7 && bp != 3'h0 ##1 $stable(bp);
  endsequence
  a_top_refused: assert property (
    s_top_req |-> ##1 array_cmd_refused)
    else $error("top region not refused");
endmodule
bind sfrwc_top sfrwc_checker #(.UPD_CYC(UPD_CYC)) u_sfrwc_checker (
  .ref_clk(ref_clk), .rst_n(rst_n), .wp_n(wp_n),
  .sector_prot_req(sector_prot_req), .sector_region(sector_region),
  .status_register_1(status_register_1),
  .configuration_register(configuration_register),
  .bank_address_register(bank_address_register),
  .extended_addr_enable(extended_addr_enable),
  .array_cmd_refused(array_cmd_refused)
);
`default_nettype wire

//--- tb/sfrwc_host.sv
// Purpose: Host controller model driving select, link clock and data.
// Assumes: Mode 0, link clock 800 ns, idle low between frames.
// Notes:   Data line shows the inverse of its last bit once released.
`timescale 1ns/1ps
`default_nettype none
module sfrwc_host (
  input  wire logic ref_clk,
  output logic      cs_n,
  output logic      sck,
  output logic      si
);
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end
  task automatic hw(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic frame(input logic [23:0] d, input int nb);
    @(posedge ref_clk);
    cs_n <= 1'b0;
    for (int i = nb - 1; i >= 0; i--) begin
      si <= d[i];
      hw(4);
      sck <= 1'b1;
      hw(4);
      sck <= 1'b0;
    end
    hw(4);
    cs_n <= 1'b1;
    si <= ~si;
    hw(8);
  endtask
  task automatic write_enable_cmd;
    frame(24'h00_0006, 8);
  endtask
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// Purpose: Self-checking bench for the register-write control block.
// Assumes: Host model drives the link; bench drives the rest.
// Notes:   UPD_CYC shortened to 12 cycles.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic       ref_clk = 1'b0;
  logic       rst_n, wp_n, upd_fail, upd_fail_erase, sector_prot_req;
  logic [2:0] sector_region;
  logic       cs_n, sck, si, ext, refd, rej;
  logic [7:0] sr, cr, bar;
  int         n_mismatch = 0;
  int         n_tests = 0;
  int         cyc = 0;
  always #50 ref_clk = ~ref_clk;
  sfrwc_host u_sfrwc_host (.ref_clk(ref_clk), .cs_n(cs_n), .sck(sck),
    .si(si));
  sfrwc_top #(.UPD_CYC(12)) u_sfrwc_top (.ref_clk(ref_clk), .rst_n(rst_n),
    .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n), .upd_fail(upd_fail),
    .upd_fail_erase(upd_fail_erase), .sector_prot_req(sector_prot_req),
    .sector_region(sector_region), .status_register_1(sr),
    .configuration_register(cr), .bank_address_register(bar),
    .extended_addr_enable(ext), .array_cmd_refused(refd),
    .reg_write_rejected(rej));
  task automatic chk(input string nm, input logic [7:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic idle;
    for (int i = 0; i < 400 && sr[0] !== 1'b0; i++) @(posedge ref_clk);
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [15:0] v, input int nb);
    u_sfrwc_host.write_enable_cmd();
    u_sfrwc_host.frame({8'h01, v} >> (16 - nb), nb + 8);
    idle();
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n <= 1'b0;
    wp_n <= 1'b0;
    upd_fail <= 1'b0;
    upd_fail_erase <= 1'b0;
    sector_prot_req <= 1'b0;
    sector_region <= 3'h0;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk("sr_rst", sr, 8'h00);
    chk("cr_rst", cr, 8'h00);
    chk("bar_rst", bar, 8'h00);
    u_sfrwc_host.frame({8'h17, 8'h81}, 16);
    chk("bar", bar, 8'h81);
    chk("ext", {7'h00, ext}, 8'h01);
    chk("sr_bank", sr, 8'h00);
    u_sfrwc_host.frame({8'h17, 9'h000}, 17);
    chk("bar_9b", bar, 8'h81);
    u_sfrwc_host.frame({8'h01, 8'h1C}, 16);
    chk("rej", {7'h00, rej}, 8'h01);
    chk("sr_nowel", sr, 8'h00);
    u_sfrwc_host.frame(24'h00_000C, 9);
    chk("wel_9b", sr, 8'h00);
    u_sfrwc_host.write_enable_cmd();
    chk("wel", sr, 8'h02);
    u_sfrwc_host.frame({8'h01, 8'h9C}, 16);
    chk("busy", {6'h00, sr[1:0]}, 8'h03);
    idle();
    chk("sr_swd", sr, 8'h9C);
    sector_prot_req <= 1'b1;
    sector_region <= 3'h7;
    repeat (4) @(posedge ref_clk);
    chk("ref7", {7'h00, refd}, 8'h01);
    sector_region <= 3'h0;
    repeat (4) @(posedge ref_clk);
    chk("ref0", {7'h00, refd}, 8'h00);
    sector_prot_req <= 1'b0;
    wr(16'h0000, 8);
    chk("sr_hw", sr & 8'hFC, 8'h9C);
    wp_n <= 1'b1;
    wr(16'h8000, 16);
    chk("sr_sw", sr, 8'h80);
    wp_n <= 1'b0;
    wr(16'h0000, 8);
    chk("sr_hw2", sr & 8'hFC, 8'h80);
    wp_n <= 1'b1;
    wr(16'h8002, 16);
    wp_n <= 1'b0;
    wr(16'h0002, 16);
    chk("sr_quad", sr, 8'h00);
    chk("cr_quad", cr, 8'h02);
    wr(16'h0000, 16);
    chk("cr_clr", cr, 8'h00);
    u_sfrwc_host.write_enable_cmd();
    u_sfrwc_host.frame(24'h00_19C0, 20);
    chk("sr_20b", sr, 8'h02);
    upd_fail <= 1'b1;
    for (int e = 0; e < 2; e++) begin
      upd_fail_erase <= e[0];
      wr(16'h0000, 8);
      chk("fail", sr & 8'h60, e[0] ? 8'h20 : 8'h40);
      u_sfrwc_host.frame(24'h00_0030, 8);
      idle();
    end
    upd_fail <= 1'b0;
    u_sfrwc_host.frame(24'h00_00B9, 8);
    u_sfrwc_host.frame({8'h01, 8'h7E}, 16);
    chk("bar_leg", bar, 8'h82);
    chk("sr_leg", sr & 8'hFC, 8'h00);
    u_sfrwc_host.frame({8'h01, 8'h00}, 16);
    chk("bar_cls", bar, 8'h82);
    u_sfrwc_host.frame(24'h00_00B9, 8);
    wr(16'h0000, 8);
    chk("bar_cls2", bar, 8'h82);
    end_sim();
  end
endmodule
`default_nettype wire
